// [design/serial_port_pkg.sv]
`default_nettype none

package serial_port_pkg;

	// Byte addresses in the special function register space
	localparam logic [7:0] CTRL_ADDR      = 8'h98;
	localparam logic [7:0] DATA_ADDR      = 8'h99;
	localparam logic [7:0] FRAC_DIV_ADDR  = 8'h9D;
	localparam logic [7:0] TIMER_ERR_ADDR = 8'h9E;

	// Bit-addressable window: 0x98 .. 0x9F maps onto control bits 0 .. 7
	localparam logic [4:0] CTRL_BIT_BASE  = 5'h13;

	// Control register field positions
	localparam int MODE_HI_POS   = 7;
	localparam int MODE_LO_POS   = 6;
	localparam int ADDR_FILT_POS = 5;
	localparam int RX_EN_POS     = 4;
	localparam int TX_NINTH_POS  = 3;
	localparam int RX_NINTH_POS  = 2;
	localparam int TX_DONE_POS   = 1;
	localparam int RX_DONE_POS   = 0;

	// Timer/error register field positions
	localparam int OVERRUN_POS   = 7;
	localparam int FRAME_ERR_POS = 6;
	localparam int BREAK_ERR_POS = 5;
	localparam int EXT_RATIO_LSB = 3;
	localparam int DIV_SEL_LSB   = 0;

	// Reset values
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam logic [7:0] DATA_RESET      = 8'h00;
	localparam logic [7:0] FRAC_DIV_RESET  = 8'h00;
	localparam logic [7:0] TIMER_ERR_RESET = 8'h00;

	// Timing in core clocks
	localparam int SHIFT_DIV       = 12;
	localparam int SLOW_FIXED_DIV  = 32;
	localparam int FAST_FIXED_DIV  = 16;
	localparam int OVERSAMPLE      = 16;
	localparam int SAMPLE_PHASE    = OVERSAMPLE / 2 - 1;

	typedef enum logic [1:0] {
		MODE_SHIFT    = 2'b00,
		MODE_VAR8     = 2'b01,
		MODE_FIXED9   = 2'b10,
		MODE_VAR9     = 2'b11
	} serial_mode_t;

endpackage

`default_nettype wire

// [design/serial_rate_gen.sv]
`timescale 1ns/10ps
`default_nettype none

module serial_rate_gen #(
	parameter int CNT_W = 10
) (
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire serial_port_pkg::serial_mode_t mode,
	input  wire logic                         double_rate,
	input  wire logic                         enhanced,
	input  wire logic                         timer_tick,
	input  wire logic [2:0]                   div_sel,
	input  wire logic [1:0]                   ext_ratio,
	output logic                              os_tick_ff
);
	import serial_port_pkg::*;

	initial
	begin
		if (CNT_W < 10)
			$error("serial_rate_gen: CNT_W too small for the divider");
	end

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] period;
	logic             use_count;

	// Clocks per oversample tick
	always_comb
	begin
		use_count = 1'b1;
		period    = CNT_W'(1);
		if (mode == MODE_FIXED9)
			period = double_rate ? CNT_W'(FAST_FIXED_DIV / OVERSAMPLE)
			                     : CNT_W'(SLOW_FIXED_DIV / OVERSAMPLE);
		else if (enhanced)
			period = CNT_W'((CNT_W'(1) << div_sel) * (CNT_W'(ext_ratio) + 1'b1));
		else
			use_count = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			cnt_ff <= '0;
		else if (!use_count || cnt_ff >= period - 1'b1)
			cnt_ff <= '0;
		else
			cnt_ff <= cnt_ff + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			os_tick_ff <= 1'b0;
		else if (use_count)
			os_tick_ff <= (cnt_ff >= period - 1'b1);
		else
			os_tick_ff <= timer_tick;
	end

endmodule // serial_rate_gen

`default_nettype wire

// [design/serial_port_control.sv]
// Notes on behaviour
// - Data address write loads transmit register; read returns separate receive buffer.
// - Enhanced timer rate and error detection only with the enhanced enable set.
// - Control bits 7-6 select shift, 8-bit variable, 9-bit fixed, 9-bit variable.
// - Shift-register mode runs at core clock divided by twelve.
// - Fixed 9-bit mode runs at core clock divided by 32 or 16.
// - 8-bit mode with filter set: no receive flag without valid stop bit.
// - 9-bit modes with filter set: no receive flag when ninth bit is 0.
// - Reception starts only while receive enable, control bit 4, is set.
// - 9-bit modes transmit control bit 3 as the ninth data bit.
// - Bit 2 latches received ninth bit, or stop bit in 8-bit mode.
// - Transmit-done set after eighth bit in shift mode, else at stop start.
// - Hardware never clears transmit-done; firmware clears it.
// - Receive-done set after eighth bit in shift mode, else mid stop bit.
// - Receive-done stays set until firmware clears it.
// - Control bits addressable singly at 0x98..0x9F; other registers byte only.
// - Receive is double-buffered: buffer holds old byte while next shifts in.
// - Enhanced mode sets overrun when a character lands with receive-done set.
`timescale 1ns/10ps
`default_nettype none

module serial_port_control (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata_ff,
	input  wire logic [7:0] bit_addr,
	input  wire logic       bit_wr,
	input  wire logic       bit_wdata,
	input  wire logic       enhanced_uart_enable,
	input  wire logic       double_rate,
	input  wire logic       timer_tick,
	input  wire logic       rxd_in,
	output logic            rxd_out_ff,
	output logic            rxd_oe_ff,
	output logic            txd_ff
);
	import serial_port_pkg::*;

	typedef enum logic [4:0] {
		T_IDLE  = 5'b0_0001,
		T_START = 5'b0_0010,
		T_DATA  = 5'b0_0100,
		T_NINTH = 5'b0_1000,
		T_STOP  = 5'b1_0000
	} tx_state_t;

	typedef enum logic [5:0] {
		R_IDLE  = 6'b00_0001,
		R_START = 6'b00_0010,
		R_DATA  = 6'b00_0100,
		R_NINTH = 6'b00_1000,
		R_STOP  = 6'b01_0000,
		R_SHIFT = 6'b10_0000
	} rx_state_t;

	logic [7:0]   ctrl_ff, nxt_ctrl;
	logic [7:0]   tx_shift_ff;
	logic [7:0]   rx_shift_ff;
	logic [7:0]   rx_buf_ff;
	logic [7:0]   frac_div_ff;
	logic [7:0]   timer_err_ff, nxt_timer_err;
	logic         rx_nine_ff;
	tx_state_t    tx_st_ff;
	rx_state_t    rx_st_ff;
	logic [3:0]   tx_ph_ff, rx_ph_ff;
	logic [2:0]   tx_cnt_ff, rx_cnt_ff;
	logic         os_tick_ff;
	serial_mode_t mode;
	logic         shift_mode, nine_mode, enh;
	logic         tx_step, tx_last, rx_step, rx_last, rx_mid;
	logic         data_wr, ctrl_bit_hit, tx_load, shift_rx_go;
	logic         rx_fin, fin_bit, rx_accept, rx_load, ti_set;

	assign mode       = serial_mode_t'(ctrl_ff[MODE_HI_POS:MODE_LO_POS]);
	assign shift_mode = (mode == MODE_SHIFT);
	assign nine_mode  = ctrl_ff[MODE_HI_POS];
	assign enh        = enhanced_uart_enable;
	assign data_wr    = sfr_wr && sfr_addr == DATA_ADDR;
	assign ctrl_bit_hit = bit_wr && bit_addr[7:3] == CTRL_BIT_BASE;
	assign tx_load    = data_wr && tx_st_ff == T_IDLE && rx_st_ff != R_SHIFT;
	assign shift_rx_go = shift_mode && rx_st_ff == R_IDLE
		&& tx_st_ff == T_IDLE && ctrl_ff[RX_EN_POS] && !ctrl_ff[RX_DONE_POS];

	serial_rate_gen #(
		.CNT_W (10)
	) u_rate (
		.clk         (clk),
		.reset       (reset),
		.mode        (mode),
		.double_rate (double_rate),
		.enhanced    (enh),
		.timer_tick  (timer_tick),
		.div_sel     (timer_err_ff[DIV_SEL_LSB +: 3]),
		.ext_ratio   (timer_err_ff[EXT_RATIO_LSB +: 2]),
		.os_tick_ff  (os_tick_ff)
	);

	// Shift mode steps every core clock; UART modes step per oversample tick
	assign tx_step = shift_mode ? 1'b1 : os_tick_ff;
	assign tx_last = shift_mode ? tx_ph_ff == 4'(SHIFT_DIV - 1)
		: tx_ph_ff == 4'(OVERSAMPLE - 1);
	assign rx_step = shift_mode ? 1'b1 : os_tick_ff;
	assign rx_last = shift_mode ? rx_ph_ff == 4'(SHIFT_DIV - 1)
		: rx_ph_ff == 4'(OVERSAMPLE - 1);
	assign rx_mid  = rx_ph_ff == 4'(SAMPLE_PHASE);

	// Transmit sequencer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_st_ff  <= T_IDLE;
			tx_ph_ff  <= '0;
			tx_cnt_ff <= '0;
		end
		else if (tx_load)
		begin
			tx_st_ff  <= shift_mode ? T_DATA : T_START;
			tx_ph_ff  <= '0;
			tx_cnt_ff <= '0;
		end
		else if (tx_st_ff != T_IDLE && tx_step)
		begin
			tx_ph_ff <= tx_last ? 4'h0 : tx_ph_ff + 4'h1;
			if (tx_last)
			begin
				unique case (tx_st_ff)
					T_START: tx_st_ff <= T_DATA;
					T_DATA:
					begin
						tx_cnt_ff <= tx_cnt_ff + 3'h1;
						if (tx_cnt_ff == 3'h7)
							tx_st_ff <= shift_mode ? T_IDLE
								: (nine_mode ? T_NINTH : T_STOP);
					end
					T_NINTH: tx_st_ff <= T_STOP;
					T_STOP:  tx_st_ff <= T_IDLE;
					T_IDLE:  tx_st_ff <= T_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			tx_shift_ff <= DATA_RESET;
		else if (tx_load)
			tx_shift_ff <= sfr_wdata;
		else if (tx_st_ff == T_DATA && tx_step && tx_last)
			tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
	end

	// End of eighth bit in shift mode, start of stop bit otherwise
	assign ti_set = tx_st_ff == T_DATA && tx_step && tx_last
		&& tx_cnt_ff == 3'h7 && (shift_mode || !nine_mode)
		|| tx_st_ff == T_NINTH && tx_step && tx_last;

	// Line drivers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			txd_ff     <= 1'b1;
			rxd_out_ff <= 1'b1;
			rxd_oe_ff  <= 1'b0;
		end
		else
		begin
			rxd_oe_ff  <= shift_mode && tx_st_ff == T_DATA;
			rxd_out_ff <= tx_shift_ff[0];
			if (shift_mode)
			begin
				// Shift clock low for the first half of each bit
				if (tx_st_ff == T_DATA)
					txd_ff <= tx_ph_ff >= 4'(SHIFT_DIV / 2);
				else if (rx_st_ff == R_SHIFT)
					txd_ff <= rx_ph_ff >= 4'(SHIFT_DIV / 2);
				else
					txd_ff <= 1'b1;
			end
			else
			begin
				unique case (tx_st_ff)
					T_START: txd_ff <= 1'b0;
					T_DATA:  txd_ff <= tx_shift_ff[0];
					T_NINTH: txd_ff <= ctrl_ff[TX_NINTH_POS];
					T_STOP:  txd_ff <= 1'b1;
					T_IDLE:  txd_ff <= 1'b1;
				endcase
			end
		end
	end

	// Receive sequencer
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_st_ff  <= R_IDLE;
			rx_ph_ff  <= '0;
			rx_cnt_ff <= '0;
		end
		else if (rx_st_ff == R_IDLE)
		begin
			rx_ph_ff  <= '0;
			rx_cnt_ff <= '0;
			if (shift_rx_go)
				rx_st_ff <= R_SHIFT;
			else if (!shift_mode && ctrl_ff[RX_EN_POS] && !rxd_in)
				rx_st_ff <= R_START;
		end
		else if (rx_step)
		begin
			rx_ph_ff <= rx_last ? 4'h0 : rx_ph_ff + 4'h1;
			unique case (rx_st_ff)
				R_START:
					if (rx_mid && rxd_in)
						rx_st_ff <= R_IDLE;
					else if (rx_last)
						rx_st_ff <= R_DATA;
				R_DATA:
					if (rx_last)
					begin
						rx_cnt_ff <= rx_cnt_ff + 3'h1;
						if (rx_cnt_ff == 3'h7)
							rx_st_ff <= nine_mode ? R_NINTH : R_STOP;
					end
				R_NINTH:
					if (rx_last)
						rx_st_ff <= R_STOP;
				R_STOP:
					if (rx_mid)
						rx_st_ff <= R_IDLE;
				R_SHIFT:
					if (rx_last)
					begin
						rx_cnt_ff <= rx_cnt_ff + 3'h1;
						if (rx_cnt_ff == 3'h7)
							rx_st_ff <= R_IDLE;
					end
				R_IDLE: rx_st_ff <= R_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_shift_ff <= '0;
			rx_nine_ff  <= 1'b0;
		end
		else if (rx_step && rx_mid && rx_st_ff == R_DATA)
			rx_shift_ff <= {rxd_in, rx_shift_ff[7:1]};
		else if (rx_step && rx_ph_ff == 4'(SHIFT_DIV / 2)
			&& rx_st_ff == R_SHIFT)
			rx_shift_ff <= {rxd_in, rx_shift_ff[7:1]};
		else if (rx_step && rx_mid && rx_st_ff == R_NINTH)
			rx_nine_ff <= rxd_in;
	end

	// Frame ends mid stop bit, or after eighth bit in shift mode
	assign rx_fin = rx_step && (rx_st_ff == R_STOP && rx_mid
		|| rx_st_ff == R_SHIFT && rx_last && rx_cnt_ff == 3'h7);
	assign fin_bit = nine_mode ? rx_nine_ff : rxd_in;
	assign rx_accept = (enh || !ctrl_ff[RX_DONE_POS])
		&& (!ctrl_ff[ADDR_FILT_POS] || shift_mode || fin_bit);
	assign rx_load = rx_fin && rx_accept;

	// Buffer keeps the previous byte while the next one shifts in
	always_ff @(posedge clk)
	begin
		if (reset)
			rx_buf_ff <= DATA_RESET;
		else if (rx_load)
			rx_buf_ff <= rx_shift_ff;
	end

	// Control register: firmware write, then hardware sets win
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (sfr_wr && sfr_addr == CTRL_ADDR)
			nxt_ctrl = sfr_wdata;
		if (ctrl_bit_hit)
			nxt_ctrl[bit_addr[2:0]] = bit_wdata;
		if (ti_set)
			nxt_ctrl[TX_DONE_POS] = 1'b1;
		if (rx_load)
		begin
			nxt_ctrl[RX_DONE_POS] = 1'b1;
			if (!shift_mode)
				nxt_ctrl[RX_NINTH_POS] = fin_bit;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			ctrl_ff <= CTRL_RESET;
		else
			ctrl_ff <= nxt_ctrl;
	end

	// Timer/error register
	always_comb
	begin
		nxt_timer_err = timer_err_ff;
		if (sfr_wr && sfr_addr == TIMER_ERR_ADDR)
		begin
			nxt_timer_err[4:0] = sfr_wdata[4:0];
			if (!sfr_wdata[OVERRUN_POS])
				nxt_timer_err[OVERRUN_POS] = 1'b0;
		end
		if (rx_fin && enh && !shift_mode)
		begin
			nxt_timer_err[FRAME_ERR_POS] = !rxd_in;
			nxt_timer_err[BREAK_ERR_POS] = !rxd_in
				&& rx_shift_ff == 8'h00 && !(nine_mode && rx_nine_ff);
		end
		if (rx_fin && enh && ctrl_ff[RX_DONE_POS])
			nxt_timer_err[OVERRUN_POS] = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			timer_err_ff <= TIMER_ERR_RESET;
			frac_div_ff  <= FRAC_DIV_RESET;
		end
		else
		begin
			timer_err_ff <= nxt_timer_err;
			if (sfr_wr && sfr_addr == FRAC_DIV_ADDR)
				frac_div_ff <= sfr_wdata;
		end
	end

	// Registered read port; unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (reset)
			sfr_rdata_ff <= 8'h00;
		else if (sfr_rd)
		begin
			unique case (sfr_addr)
				CTRL_ADDR:      sfr_rdata_ff <= ctrl_ff;
				DATA_ADDR:      sfr_rdata_ff <= rx_buf_ff;
				FRAC_DIV_ADDR:  sfr_rdata_ff <= frac_div_ff;
				TIMER_ERR_ADDR: sfr_rdata_ff <= timer_err_ff;
				default:        sfr_rdata_ff <= 8'h00;
			endcase
		end
	end

	a_tx_done_stop: assert property (@(posedge clk) disable iff (reset)
		tx_st_ff == T_NINTH && $past(tx_st_ff) == T_DATA
		|-> ctrl_ff[TX_DONE_POS] == $past(ctrl_ff[TX_DONE_POS])
		|| $past(sfr_wr || bit_wr))
		else $error("tx done changed during ninth bit");
	a_tx_done_hold: assert property (@(posedge clk) disable iff (reset)
		ctrl_ff[TX_DONE_POS] && !sfr_wr && !bit_wr
		|=> ctrl_ff[TX_DONE_POS])
		else $error("tx done cleared by hardware");
	a_rx_done_hold: assert property (@(posedge clk) disable iff (reset)
		ctrl_ff[RX_DONE_POS] && !sfr_wr && !bit_wr
		|=> ctrl_ff[RX_DONE_POS])
		else $error("rx done cleared by hardware");
	a_filter_drop: assert property (@(posedge clk) disable iff (reset)
		rx_fin && nine_mode && ctrl_ff[ADDR_FILT_POS] && !rx_nine_ff
		&& !ctrl_ff[RX_DONE_POS] && !sfr_wr && !bit_wr
		|=> !ctrl_ff[RX_DONE_POS])
		else $error("filtered frame raised rx done");
	a_rx_enable_gate: assert property (@(posedge clk) disable iff (reset)
		rx_st_ff == R_IDLE && !ctrl_ff[RX_EN_POS] |=> rx_st_ff == R_IDLE)
		else $error("reception started while disabled");
	a_shift_clock: assert property (@(posedge clk) disable iff (reset)
		shift_mode && tx_st_ff == T_DATA && $fell(txd_ff)
		|-> !txd_ff [*6] ##1 txd_ff)
		else $error("shift clock low phase not six cycles");
	a_ninth_sent: assert property (@(posedge clk) disable iff (reset)
		!shift_mode && tx_st_ff == T_NINTH && $past(tx_st_ff) == T_NINTH
		|-> txd_ff == ctrl_ff[TX_NINTH_POS])
		else $error("ninth bit not driven from control bit 3");
	a_buf_split: assert property (@(posedge clk) disable iff (reset)
		data_wr && !rx_load |=> rx_buf_ff == $past(rx_buf_ff))
		else $error("data write disturbed the receive buffer");
	a_overrun_set: assert property (@(posedge clk) disable iff (reset)
		rx_fin && enh && ctrl_ff[RX_DONE_POS] |=> timer_err_ff[OVERRUN_POS])
		else $error("overrun not flagged");
	a_rb8_latch: assert property (@(posedge clk) disable iff (reset)
		rx_load && !shift_mode |=> ctrl_ff[RX_NINTH_POS] == $past(fin_bit))
		else $error("received ninth or stop bit not latched");

endmodule // serial_port_control

`default_nettype wire

// [test/serial_partner.sv]
`timescale 1ns/10ps
`default_nettype none

module serial_partner (
	input  wire logic clk,
	input  wire logic txd,
	output var logic  rxd_drv
);
	int         bit_len = 16;
	int         nbits   = 9;
	logic       listen  = 1'b1;
	logic [9:0] word;
	event       got;

	initial
	begin
		rxd_drv = 1'b1;
	end

	// One frame on the receive pin, then two idle bit times
	task automatic send(input logic [8:0] val, input logic stop);
		for (int i = 0; i < nbits + 2; i++)
		begin
			@(posedge clk);
			rxd_drv <= (i == 0) ? 1'b0 : (i > nbits) ? stop : val[i - 1];
			repeat (bit_len - 1) @(posedge clk);
		end
		@(posedge clk);
		rxd_drv <= 1'b1;
		repeat (2 * bit_len) @(posedge clk);
	endtask

	// Samples on falling clock edges so the sample never races the pin
	always
	begin
		@(negedge txd);
		if (listen)
		begin
			word = 10'h000;
			repeat (bit_len / 2) @(negedge clk);
			for (int i = 1; i <= nbits + 1; i++)
			begin
				repeat (bit_len) @(negedge clk);
				if (i > nbits)
					word[9] = txd;
				else
					word[i - 1] = txd;
			end
			-> got;
		end
	end

endmodule // serial_partner

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import serial_port_pkg::*;

	logic        clk                  = 1'b0;
	logic        reset                = 1'b1;
	logic [7:0]  sfr_addr             = 8'h00;
	logic        sfr_wr               = 1'b0;
	logic        sfr_rd               = 1'b0;
	logic [7:0]  sfr_wdata            = 8'h00;
	logic [7:0]  bit_addr             = 8'h00;
	logic        bit_wr               = 1'b0;
	logic        bit_wdata            = 1'b0;
	logic        enhanced_uart_enable = 1'b0;
	logic        double_rate          = 1'b0;
	logic        timer_tick           = 1'b1;
	logic        rd_seen              = 1'b0;
	logic [7:0]  sfr_rdata_ff;
	logic        rxd_out_ff;
	logic        rxd_oe_ff;
	logic        txd_ff;
	logic        rxd_drv;
	wire         rxd_line = rxd_oe_ff ? rxd_out_ff : rxd_drv;
	int          bad_count = 0;
	int          n_checks  = 0;
	logic [15:0] reg_q[$];
	logic [9:0]  frm_q[$];

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	serial_port_control serial_port_control_inst (
		.clk                  (clk),
		.reset                (reset),
		.sfr_addr             (sfr_addr),
		.sfr_wr               (sfr_wr),
		.sfr_rd               (sfr_rd),
		.sfr_wdata            (sfr_wdata),
		.sfr_rdata_ff         (sfr_rdata_ff),
		.bit_addr             (bit_addr),
		.bit_wr               (bit_wr),
		.bit_wdata            (bit_wdata),
		.enhanced_uart_enable (enhanced_uart_enable),
		.double_rate          (double_rate),
		.timer_tick           (timer_tick),
		.rxd_in               (rxd_line),
		.rxd_out_ff           (rxd_out_ff),
		.rxd_oe_ff            (rxd_oe_ff),
		.txd_ff               (txd_ff)
	);

	serial_partner serial_partner_inst (
		.clk     (clk),
		.txd     (txd_ff),
		.rxd_drv (rxd_drv)
	);

	task automatic err(input string s);
		bad_count++;
		$display("ERROR %0t %s", $time, s);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Masked compare: expectation holds {mask, value}
	task automatic cmp_reg(input logic [7:0] got);
		logic [15:0] e;
		n_checks++;
		if (reg_q.size() == 0)
			err("unexpected read");
		else
		begin
			e = reg_q.pop_front();
			if ((got & e[15:8]) !== e[7:0])
				err("register read mismatch");
		end
	endtask

	task automatic cmp_frame(input logic [9:0] got);
		n_checks++;
		if (frm_q.size() == 0)
			err("unexpected frame");
		else if (got !== frm_q.pop_front())
			err("frame mismatch");
	endtask

	always @(posedge clk)
	begin
		if (rd_seen)
			cmp_reg(sfr_rdata_ff);
		rd_seen <= sfr_rd;
	end

	always @(serial_partner_inst.got)
		cmp_frame(serial_partner_inst.word);

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		reg_q.push_back({m, e});
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
	endtask

	task automatic bw(input logic [7:0] a, input logic v);
		@(negedge clk);
		bit_addr = a;
		bit_wdata = v;
		bit_wr = 1'b1;
		@(negedge clk);
		bit_wr = 1'b0;
	endtask

	task automatic wait_frames();
		for (int t = 0; t < 2000 && frm_q.size() > 0; t++)
			@(posedge clk);
		if (frm_q.size() > 0)
		begin
			err("frame missing");
			summarize();
		end
	endtask

	// Collects shift-mode data at each rising shift clock
	task automatic shift_cap();
		logic [9:0] w;
		logic       p;
		int         last;
		int         n;
		w = 10'h200;
		p = 1'b1;
		last = 0;
		n = 0;
		for (int t = 0; t < 200 && n < 8; t++)
		begin
			@(posedge clk);
			#1;
			if (txd_ff && !p)
			begin
				if (n > 0 && t - last != SHIFT_DIV)
					w[9] = 1'b0;
				w[n] = rxd_line;
				n++;
				last = t;
			end
			p = txd_ff;
		end
		cmp_frame(w);
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		err("timeout");
		summarize();
	end

	initial
	begin
		logic [7:0] a;
		logic [7:0] c;
		logic [7:0] cfg[4];
		int         len[4];
		logic [7:0] ra[5];
		cfg = '{8'h88, 8'h80, 8'h40, 8'hC8};
		len = '{16, 32, 16, 16};
		ra = '{CTRL_ADDR, DATA_ADDR, FRAC_DIV_ADDR, TIMER_ERR_ADDR, 8'h9A};
		void'($urandom(32'h6c8d_6f89));
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		foreach (ra[i])
			rd(ra[i], 8'h00, 8'hFF);
		wr(FRAC_DIV_ADDR, 8'hA5);
		rd(FRAC_DIV_ADDR, 8'hA5, 8'hFF);
		wr(TIMER_ERR_ADDR, 8'hFF);
		rd(TIMER_ERR_ADDR, 8'h1F, 8'h7F);
		wr(TIMER_ERR_ADDR, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			wr(CTRL_ADDR, cfg[k]);
			double_rate = (k == 0);
			serial_partner_inst.bit_len = len[k];
			serial_partner_inst.nbits = cfg[k][7] ? 9 : 8;
			a = 8'($urandom);
			frm_q.push_back({1'b1, cfg[k][7] & cfg[k][3], a});
			wr(DATA_ADDR, a);
			rd(DATA_ADDR, 8'h00, 8'hFF);
			wait_frames();
			repeat (40) @(negedge clk);
			rd(CTRL_ADDR, cfg[k] | 8'h02, 8'hFF);
			bw(8'h99, 1'b0);
			rd(CTRL_ADDR, cfg[k], 8'hFF);
		end
		serial_partner_inst.listen = 1'b0;
		wr(CTRL_ADDR, 8'h00);
		a = 8'($urandom);
		frm_q.push_back({1'b1, 1'b0, a});
		wr(DATA_ADDR, a);
		shift_cap();
		// Transmit-done comes at the end of the eighth bit, after its rise
		repeat (12) @(negedge clk);
		rd(CTRL_ADDR, 8'h02, 8'h02);
		bw(8'h99, 1'b0);
		// Shift-mode receive of an idle-high line; stops once rx done is set
		wr(CTRL_ADDR, 8'h10);
		repeat (120) @(negedge clk);
		rd(CTRL_ADDR, 8'h11, 8'hFF);
		rd(DATA_ADDR, 8'hFF, 8'hFF);
		serial_partner_inst.listen = 1'b1;
		double_rate = 1'b1;
		serial_partner_inst.bit_len = 16;
		serial_partner_inst.nbits = 9;
		wr(CTRL_ADDR, 8'hA0);
		bw(8'h9C, 1'b1);
		a = 8'($urandom);
		c = 8'($urandom);
		serial_partner_inst.send({1'b1, a}, 1'b1);
		rd(CTRL_ADDR, 8'hB5, 8'hFF);
		serial_partner_inst.send({1'b1, c}, 1'b1);
		rd(DATA_ADDR, a, 8'hFF);
		rd(CTRL_ADDR, 8'h01, 8'h01);
		rd(TIMER_ERR_ADDR, 8'h00, 8'h80);
		bw(8'h98, 1'b0);
		serial_partner_inst.send({1'b0, c}, 1'b1);
		rd(CTRL_ADDR, 8'h00, 8'h01);
		bw(8'h9C, 1'b0);
		serial_partner_inst.send({1'b1, c}, 1'b1);
		rd(CTRL_ADDR, 8'h00, 8'h01);
		serial_partner_inst.nbits = 8;
		wr(CTRL_ADDR, 8'h70);
		serial_partner_inst.send({1'b0, c}, 1'b0);
		rd(CTRL_ADDR, 8'h00, 8'h01);
		serial_partner_inst.send({1'b0, c}, 1'b1);
		rd(CTRL_ADDR, 8'h05, 8'h05);
		rd(DATA_ADDR, c, 8'hFF);
		bw(8'h98, 1'b0);
		enhanced_uart_enable = 1'b1;
		serial_partner_inst.nbits = 9;
		wr(CTRL_ADDR, 8'hD0);
		serial_partner_inst.send({1'b1, a}, 1'b1);
		serial_partner_inst.send({1'b1, c}, 1'b1);
		rd(TIMER_ERR_ADDR, 8'h80, 8'h80);
		rd(DATA_ADDR, c, 8'hFF);
		wr(TIMER_ERR_ADDR, 8'h00);
		rd(TIMER_ERR_ADDR, 8'h00, 8'h80);
		serial_partner_inst.send({1'b1, a}, 1'b0);
		rd(TIMER_ERR_ADDR, 8'h40, 8'h40);
		repeat (4) @(negedge clk);
		summarize();
	end

endmodule // testbench

`default_nettype wire
